// ### bdsd_glue.sv
module bdsd_glue
  import bdsd_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // processor bus, active low strobes
  input  wire logic [CPU_ADDR_W-1:0] cpu_addr,
  input  wire logic                  cpu_memory_request_n,
  input  wire logic                  cpu_io_request_n,
  input  wire logic                  cpu_read_n,
  input  wire logic                  cpu_refresh_cycle_n,
  input  wire logic [7:0]            cpu_data_out,
  output logic      [7:0]            cpu_data_in,
  output logic                       cpu_data_oe,
  output logic                       cpu_int_n,
  // select lines
  output logic                       rom_chip_select_n,
  output logic [PORT_COUNT-1:0]      port_select_n,
  output logic                       buffer_to_cpu,
  // dram side
  output logic [DRAM_PINS-1:0]       dram_addr,
  output bdsd_strobe_t               dram_strobe,
  output logic                       column_address_switch_n,
  output logic                       delayed_column_switch_n,
  output logic [MEM_ADDR_W-1:0]      mem_addr,
  // front panel and pins
  input  wire logic [7:0]            panel_inputs,
  input  wire logic                  ring_detect_n,
  output logic [LAMP_W-1:0]          lamps,
  output logic                       end_cue,
  output logic                       line_relay,
  output logic                       auto_lamp,
  output logic                       counter_count
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (LOW_BITS + BANK_BITS != MEM_ADDR_W) begin : g_bad_width
    $error("address widths do not add up");
  end
  if (2 * DRAM_PINS > MEM_ADDR_W) begin : g_bad_pins
    $error("too many dram pins");
  end
  // the cas decoder and the port decoder are fixed four-way decoders
  if (DRAM_ROWS != 4 || PORT_COUNT != 4) begin : g_bad_ways
    $error("decoders serve exactly four ways");
  end
  // both row pick bits must sit inside the bank field
  if (BANK_ROW_LO + 2 > BANK_BITS) begin : g_bad_row_field
    $error("row pick bits outside bank field");
  end

  // one-hot decode of a 2-bit field, active low
  function automatic logic [3:0] dec2_n(input logic [1:0] sel, input logic en);
    dec2_n = en ? ~(4'h1 << sel) : 4'hF;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [7:0] panel_s1;       // first stage, read only by second
  logic [7:0] panel_s2;       // sampled panel inputs
  logic       ring_s1;        // first stage
  logic       ring_s2;        // synchronised ring level
  // two stages keep metastability off the bus
  always_ff @(posedge sys_clk) begin
    panel_s1 <= panel_inputs;
    panel_s2 <= panel_s1;
    ring_s1  <= ring_detect_n;
    ring_s2  <= ring_s1;
  end

  // ****************************************
  // decoding
  // ****************************************
  wire top_address_bit = cpu_addr[TOP_BIT];
  wire mem_req         = ~cpu_memory_request_n;
  wire io_req          = ~cpu_io_request_n;
  assign rom_chip_select_n = ~(mem_req & ~top_address_bit);
  wire [3:0] sel_n = dec2_n(cpu_addr[1:0], io_req);
  assign port_select_n = sel_n;
  wire port_select_three = ~sel_n[PORT_INPUT];
  assign buffer_to_cpu = ~cpu_read_n;

  // ****************************************
  // io ports
  // ****************************************
  logic [7:0] lamp_port;      // lamps, cue, relay
  logic [7:0] bank_port;      // bank bits plus panel lines
  logic [7:0] spare_port;     // unused latch
  logic       sel_lamp_q;     // previous select levels for edges
  logic       sel_bank_q;
  logic       sel_spare_q;
  wire lamp_go  = ~sel_n[PORT_LAMPS] & ~sel_lamp_q;
  wire bank_go  = ~sel_n[PORT_BANK] & ~sel_bank_q;
  wire spare_go = ~sel_n[PORT_SPARE] & ~sel_spare_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lamp_port   <= PORT_RESET;
      bank_port   <= PORT_RESET;
      spare_port  <= PORT_RESET;
      sel_lamp_q  <= 1'b0;
      sel_bank_q  <= 1'b0;
      sel_spare_q <= 1'b0;
    end else begin
      sel_lamp_q  <= ~sel_n[PORT_LAMPS];
      sel_bank_q  <= ~sel_n[PORT_BANK];
      sel_spare_q <= ~sel_n[PORT_SPARE];
      if (lamp_go) begin
        lamp_port <= cpu_data_out;
      end
      if (bank_go) begin
        bank_port <= cpu_data_out;
      end
      if (spare_go) begin
        spare_port <= cpu_data_out;
      end
    end
  end
  // input port drives only while selected
  assign cpu_data_in = port_select_three ? panel_s2 : 8'h00;
  assign cpu_data_oe = port_select_three & ~cpu_read_n;
  assign lamps         = lamp_port[LAMP_W-1:0];
  assign end_cue       = lamp_port[LAMP_CUE];
  assign line_relay    = lamp_port[LAMP_RELAY];
  assign auto_lamp     = bank_port[BANK_AUTO];
  assign counter_count = bank_port[BANK_COUNT];
  assign cpu_int_n = ring_s2;

  // ****************************************
  // dram address and strobes
  // ****************************************
  // bank bits extend the address
  assign mem_addr = {bank_port[BANK_BITS-1:0], cpu_addr[LOW_BITS-1:0]};
  wire [1:0] row_pick = {bank_port[BANK_ROW_LO+1], bank_port[BANK_ROW_LO]};
  wire row_pick_bit_low  = row_pick[0];
  wire row_pick_bit_high = row_pick[1];
  wire qualified_request = mem_req & cpu_refresh_cycle_n;
  logic col_q;                // registered request
  // switch one edge later; drop with request
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      col_q <= 1'b0;
    end else begin
      col_q <= qualified_request;
    end
  end
  wire col_on = col_q & qualified_request;
  assign column_address_switch_n = ~col_on;
  // low bits while the row strobe opens
  assign dram_addr = col_on ? mem_addr[2*DRAM_PINS-1:DRAM_PINS] : mem_addr[DRAM_PINS-1:0];
  // delayed switch taken from the mux path
  assign delayed_column_switch_n = ~col_on;
  assign dram_strobe.ras_n = ~qualified_request;
  assign dram_strobe.we_n  = ~(qualified_request & cpu_read_n);
  // one row cas, dram half only
  assign dram_strobe.cas_n = dec2_n({row_pick_bit_high, row_pick_bit_low},
                                    ~delayed_column_switch_n & top_address_bit);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  rom_sel_a:    assert property (!rom_chip_select_n == (mem_req && !cpu_addr[TOP_BIT]))
    else $error("rom select wrong");
  port_one_a:   assert property (io_req |-> $onehot(~port_select_n))
    else $error("port select not one-hot");
  bank_latch_a: assert property (bank_go |=> bank_port == $past(cpu_data_out))
    else $error("bank port missed data");
  cpu_refresh_cycle_quiet_a: assert property (!cpu_refresh_cycle_n |-> dram_strobe.ras_n && &dram_strobe.cas_n)
    else $error("strobe in refresh");
  ras_row_a:    assert property ($rose(qualified_request) |-> dram_addr == cpu_addr[8:0])
    else $error("row address absent");
  we_write_a:   assert property (!dram_strobe.we_n == (qualified_request && cpu_read_n))
    else $error("write enable wrong");
  col_delay_a:  assert property (qualified_request [*2] |-> !column_address_switch_n)
    else $error("switch late");
  cas_rom_a:    assert property (!top_address_bit |-> &dram_strobe.cas_n)
    else $error("cas on rom access");
  // only the row named by the bank port may see a column strobe
  cas_pick_a:   assert property (!(&dram_strobe.cas_n)
                  |-> ~dram_strobe.cas_n == (4'h1 << row_pick))
    else $error("wrong row strobed");
  release_a:    assert property (!qualified_request |-> dram_strobe.ras_n
                  && column_address_switch_n && dram_strobe.we_n)
    else $error("strobes held");
  // interrupt follows the ring pin two edges late, through the synchroniser
  ring_int_a:   assert property (cpu_int_n == $past(ring_detect_n, 2))
    else $error("ring missed");
  cov_write_c:  cover property (qualified_request && cpu_read_n ##1 !(&dram_strobe.cas_n));
  cov_read_c:   cover property (qualified_request && !cpu_read_n ##1 !(&dram_strobe.cas_n));
  cov_bank_c:   cover property (bank_go);
  cov_cpu_refresh_cycle_c:   cover property (mem_req && !cpu_refresh_cycle_n);
endmodule

// ### bdsd_pkg.sv
package bdsd_pkg;
  // ****************************************
  // address layout
  // ****************************************
  localparam int CPU_ADDR_W  = 16;   // processor address bus
  localparam int LOW_BITS    = 15;   // bits taken straight from the processor
  localparam int BANK_BITS   = 5;    // bits held in the bank select port
  localparam int MEM_ADDR_W  = 20;   // full memory address
  localparam int DRAM_PINS   = 9;    // shared row/column address pins
  localparam int DRAM_ROWS   = 4;    // rows of memory chips
  localparam int TOP_BIT     = 15;   // address bit that splits rom from dram
  localparam int PORT_COUNT  = 4;    // io port selects
  // bank port field positions
  localparam int BANK_ROW_LO = 3;    // row pick bit low position
  localparam int BANK_AUTO   = 5;    // auto-mode indicator
  localparam int BANK_COUNT  = 6;    // front-panel counter count line
  // port numbers
  localparam logic [1:0] PORT_LAMPS = 2'h0;
  localparam logic [1:0] PORT_BANK  = 2'h1;
  localparam logic [1:0] PORT_SPARE = 2'h2;
  localparam logic [1:0] PORT_INPUT = 2'h3;
  // lamp port fields
  localparam int LAMP_W      = 5;
  localparam int LAMP_CUE    = 5;
  localparam int LAMP_RELAY  = 6;
  // reset values of the output ports
  localparam logic [7:0] PORT_RESET = 8'h00;

  // dram strobe group, all active low
  typedef struct packed {
    logic                 ras_n;
    logic [DRAM_ROWS-1:0] cas_n;
    logic                 we_n;
  } bdsd_strobe_t;
endpackage

// ### bdsd_dram_model.sv
// ****************************************
// four rows of one-bit memory chips
// ****************************************
module bdsd_dram_model
  import bdsd_pkg::*;
(
  // shared address pins and strobes
  input  wire logic [DRAM_PINS-1:0] dram_addr,
  input  wire bdsd_strobe_t         dram_strobe,
  // last access as the chips saw it
  output logic      [17:0]          seen_addr,
  output logic      [1:0]           seen_row,
  output logic                      seen_we
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DRAM_PINS-1:0] row_latch;  // row half, held inside the chip
  // row half on row strobe
  // sample a moment after the strobe so the pins have settled
  always @(negedge dram_strobe.ras_n) begin
    #1;
    row_latch = dram_addr;
  end
  // column half on strobe of one row
  always @(negedge (&dram_strobe.cas_n)) begin
    #1;
    seen_addr = {dram_addr, row_latch};
    seen_we   = dram_strobe.we_n;
    // last low strobe wins; two low would be a decode fault
    for (int i = 0; i < DRAM_ROWS; i++) if (!dram_strobe.cas_n[i]) seen_row = 2'(i);
  end
endmodule

// ### testbench.sv
module testbench;
  import bdsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // bench signals
  // ****************************************
  logic sys_clk = 1'b0, sys_rst = 1'b1;  // clock and sync reset
  logic [15:0] addr = 16'h0000;  // processor address
  logic mem_req_n = 1'b1, io_req_n = 1'b1, rd_n = 1'b1, refr_n = 1'b1;  // bus strobes
  logic [7:0] wdata = 8'h00, panel = 8'h00;  // write data, panel pins
  logic ring_n = 1'b1;  // ring detector
  logic [7:0] din;  // input port data
  logic oe, int_n, rom_n, to_cpu, sw_n, dsw_n, cue, relay, auto_l, cnt_l;
  logic [3:0] sel_n;  // io port selects
  logic [8:0] daddr;  // dram address pins
  logic [19:0] maddr;  // full memory address
  logic [4:0] lamps;  // indicator lamps
  logic [17:0] seen_addr;  // model view
  logic [1:0] seen_row;
  logic seen_we;
  bdsd_strobe_t strobe;  // dram strobes
  int error_cnt = 0, checked = 0, seed = 32'hd64e;
  logic [7:0] bank = 8'h00;  // bench copy of bank port
  logic [7:0] d;  // scratch data
  bdsd_glue bdsd_glue_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .cpu_addr(addr),
    .cpu_memory_request_n(mem_req_n), .cpu_io_request_n(io_req_n), .cpu_read_n(rd_n),
    .cpu_refresh_cycle_n(refr_n), .cpu_data_out(wdata), .cpu_data_in(din), .cpu_data_oe(oe),
    .cpu_int_n(int_n), .rom_chip_select_n(rom_n), .port_select_n(sel_n),
    .buffer_to_cpu(to_cpu), .dram_addr(daddr), .dram_strobe(strobe),
    .column_address_switch_n(sw_n), .delayed_column_switch_n(dsw_n), .mem_addr(maddr),
    .panel_inputs(panel), .ring_detect_n(ring_n), .lamps(lamps), .end_cue(cue),
    .line_relay(relay), .auto_lamp(auto_l), .counter_count(cnt_l));
  bdsd_dram_model bdsd_dram_model_i (.dram_addr(daddr), .dram_strobe(strobe),
    .seen_addr(seen_addr), .seen_row(seen_row), .seen_we(seen_we));
  // free running 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  // ****************************************
  // tasks
  // ****************************************
  // value compare, padded to the widest result
  task chk(input logic [23:0] act, input logic [23:0] exp);
    checked++;
    if (act !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, act, exp);
    end
  endtask
  task end_of_test;
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // inputs move a fixed 2 ns after the edge
  task tick;
    @(posedge sys_clk);
    #2;
  endtask
  // one io cycle; ports latch at the first edge
  task io_op(input logic [1:0] port, input logic rd, input logic [7:0] v);
    addr = (16'($random(seed)) & 16'hfffc) | 16'(port);
    io_req_n = 1'b0;
    rd_n = !rd;
    wdata = v;
    #1 chk(sel_n, 4'(~(4'h1 << port)));
    chk(to_cpu, rd);
    if (port == PORT_INPUT) chk({oe, din}, {1'b1, panel});
    tick;
    io_req_n = 1'b1;
    rd_n = 1'b1;
    tick;
  endtask
  // one memory cycle: row phase, column phase, release
  task mem_op(input logic [15:0] a, input logic rd, input logic rf);
    logic [19:0] m;
    m = {bank[4:0], a[14:0]};
    addr = a;
    mem_req_n = 1'b0;
    rd_n = !rd;
    refr_n = !rf;
    #1 chk(rom_n, a[15]);
    chk(strobe.ras_n, rf);
    chk(strobe.we_n, rf | rd);
    chk(daddr, m[8:0]);
    tick;
    chk({sw_n, dsw_n}, {rf, rf});
    chk(strobe.cas_n, (rf || !a[15]) ? 4'hf : 4'(~(4'h1 << bank[4:3])));
    if (!rf) chk(daddr, m[17:9]);
    if (!rf && a[15]) chk({seen_we, seen_row, seen_addr}, {rd, bank[4:3], m[17:0]});
    mem_req_n = 1'b1;
    rd_n = 1'b1;
    refr_n = 1'b1;
    #1 chk({sw_n, dsw_n, strobe}, 8'hff);
    tick;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge sys_clk);
    #2 sys_rst = 1'b0;
    tick;
    chk({relay, cue, lamps, cnt_l, auto_l, maddr[19:15]}, 20'h0_0000);
    // walk the rows in order, one bank write each
    for (int r = 0; r < DRAM_ROWS; r++) begin
      bank = 8'($random(seed)) & 8'h67 | 8'(r << BANK_ROW_LO);
      io_op(PORT_BANK, 1'b0, bank);
      chk({cnt_l, auto_l, maddr[19:15]}, {bank[6:5], bank[4:0]});
      mem_op(16'($random(seed)) | 16'h8000, 1'b0, 1'b0);
      mem_op(16'($random(seed)) | 16'h8000, 1'b1, 1'b0);
    end
    d = 8'($random(seed));
    io_op(PORT_LAMPS, 1'b0, d);
    chk({relay, cue, lamps}, d[6:0]);
    io_op(PORT_SPARE, 1'b0, ~d);
    chk({cnt_l, auto_l, maddr[19:15]}, {bank[6:5], bank[4:0]});
    mem_op(16'($random(seed)) | 16'h8000, 1'b0, 1'b1);
    mem_op(16'($random(seed)) & 16'h7fff, 1'b1, 1'b0);
    // software refresh: one read for each of the first 256 of the 512 row addresses of the chips
    for (int i = 0; i < 256; i++) begin
      mem_op(16'h8000 | 16'(i), 1'b1, 1'b0);
    end
    panel = 8'($random(seed));
    repeat (3) tick;
    chk({oe, din}, 9'h000);
    io_op(PORT_INPUT, 1'b1, 8'h00);
    ring_n = 1'b0;
    repeat (4) tick;
    chk(int_n, 1'b0);
    ring_n = 1'b1;
    repeat (4) tick;
    chk(int_n, 1'b1);
    end_of_test;
  end
  // bounded run; running out counts against the design
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    end_of_test;
  end
endmodule
